// >>> shared/exs_map.svh
// register offsets, field positions and exception codes of the status block
`ifndef EXS_MAP_SVH
`define EXS_MAP_SVH
// ============================================================
// register offsets (word index, byte address = 4 * index)
`define EXS_OFF_STATUS     4'h0
`define EXS_OFF_IRQ_STAT   4'h1
`define EXS_OFF_IRQ_EN     4'h2
`define EXS_OFF_IRQ_CLR    4'h3
`define EXS_OFF_PERIPH     4'h4
// ============================================================
// field positions
`define EXS_ACT_LSB        0
`define EXS_ACT_MSB        6
`define EXS_RSV_LSB        7
`define EXS_RSV_MSB        10
`define EXS_TO_BASE_BIT    11
`define EXS_PEND_LSB       12
`define EXS_PEND_MSB       18
// ============================================================
// exception numbers
`define EXS_EXC_NONE       7'h00
`define EXS_EXC_NMI        7'h02
`define EXS_EXC_HARD       7'h03
`define EXS_EXC_MEM        7'h04
`define EXS_EXC_BUS        7'h05
`define EXS_EXC_USAGE      7'h06
`define EXS_EXC_SVC        7'h0B
`define EXS_EXC_DEBUG      7'h0C
`define EXS_EXC_PENDSVC    7'h0E
`define EXS_EXC_TICK       7'h0F
`define EXS_EXC_IRQ_FIRST  7'h10
`define EXS_EXC_IRQ_LAST   7'h3F
`define EXS_IRQ_BASE       7'h10
`define EXS_RESET_VAL      32'h0000_0800
`define EXS_NEST_DEPTH     8
`endif

// >>> shared/exs_pkg.sv
// types shared by the exception status block
`default_nettype none
package exs_pkg;
    // ============================================================
    // exception event from the core
    typedef struct packed {
        logic       entry;
        logic       ret;
        logic [6:0] num;
    } exs_evt_t;

    typedef enum logic [2:0] {
        EXS_IDLE = 3'b001,
        EXS_ACK  = 3'b010,
        EXS_DONE = 3'b100
    } exs_bus_st_t;
endpackage
`default_nettype wire

// >>> rtl/exs_status.sv
// exception state status fields with avalon-mm register access
//
// Functional notes
// - system exception codes: usage, call, pended service, tick
// - peripheral vectors 0..47 map to 0x10..0x3F
// - bit 11 low while preempted exceptions remain (here low only while two or more ordinary interrupts are active)
// - only ordinary interrupts count for bit 11
// - bits 10:7 read as zero
// - bits 6:0 hold active exception, reset zero
// - active field zero means thread mode
// - active field mirrors service routine number
// - bits 18:12 hold highest pending exception
//
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "exs_map.svh"
module exs_status (
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        exc_entry_i,
    input  wire logic        exc_return_i,
    input  wire logic [6:0]  exc_num_i,
    input  wire logic [6:0]  pend_num_i,
    output logic      [6:0]  service_routine_number_o,
    output logic             irq_o
);
    // ============================================================
    // helpers
    function automatic logic is_ordinary(input logic [6:0] n);
        // usage fault is a fault too, so it never counts as nesting
        is_ordinary = (n > `EXS_EXC_USAGE);
    endfunction

    function automatic logic valid_code(input logic [6:0] n);
        valid_code = (n == `EXS_EXC_NMI) || (n == `EXS_EXC_HARD) ||
                     (n == `EXS_EXC_MEM) || (n == `EXS_EXC_BUS) ||
                     (n == `EXS_EXC_USAGE) || (n == `EXS_EXC_SVC) ||
                     (n == `EXS_EXC_PENDSVC) ||
                     (n == `EXS_EXC_TICK) ||
                     ((n >= `EXS_EXC_IRQ_FIRST) &&
                      (n <= `EXS_EXC_IRQ_LAST));
    endfunction

    exs_pkg::exs_evt_t evt;
    assign evt.entry = exc_entry_i && valid_code(exc_num_i);
    assign evt.ret   = exc_return_i;
    assign evt.num   = exc_num_i;

    // ============================================================
    // nesting stack: each level remembers the number it preempted
    logic [6:0] stack_q [`EXS_NEST_DEPTH];
    logic [3:0] depth_q;
    logic [3:0] ord_cnt_q;
    logic [6:0] act_q;
    logic [6:0] pend_q;
    logic       ovf_ev;
    logic       bad_ev;

    assign ovf_ev = evt.entry && (depth_q == 4'(`EXS_NEST_DEPTH));
    assign bad_ev = (exc_entry_i && !valid_code(exc_num_i)) ||
                    (evt.ret && depth_q == 4'h0);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < `EXS_NEST_DEPTH; i++) begin
                stack_q[i] <= `EXS_EXC_NONE;
            end
        end else if (evt.entry && !ovf_ev) begin
            stack_q[depth_q[2:0]] <= act_q;
        end
    end

    // active number follows entry and return; zero means thread mode
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            act_q   <= `EXS_EXC_NONE;
            depth_q <= 4'h0;
        end else if (evt.entry && !ovf_ev) begin
            act_q   <= evt.num;
            depth_q <= depth_q + 4'h1;
        end else if (evt.ret && depth_q != 4'h0) begin
            act_q   <= stack_q[3'(depth_q - 4'h1)];
            depth_q <= depth_q - 4'h1;
        end
    end

    // count of ordinary interrupts active; nmi and faults ignored
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ord_cnt_q <= 4'h0;
        end else if (evt.entry && !ovf_ev && is_ordinary(evt.num)) begin
            ord_cnt_q <= ord_cnt_q + 4'h1;
        end else if (evt.ret && depth_q != 4'h0 &&
                     is_ordinary(act_q) && ord_cnt_q != 4'h0) begin
            ord_cnt_q <= ord_cnt_q - 4'h1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_q <= `EXS_EXC_NONE;
        end else begin
            pend_q <= valid_code(pend_num_i) ? pend_num_i
                                             : `EXS_EXC_NONE;
        end
    end

    logic return_to_base_flag;
    assign return_to_base_flag = (ord_cnt_q <= 4'h1);
    assign service_routine_number_o = act_q;

    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`EXS_ACT_MSB:`EXS_ACT_LSB]   = act_q;
        status_word[`EXS_TO_BASE_BIT] = return_to_base_flag;
        status_word[`EXS_PEND_MSB:`EXS_PEND_LSB] = pend_q;
    end

    // ============================================================
    // interrupt: bit0 entry, bit1 return, bit2 overflow/bad event
    logic [2:0] ist_q;
    logic [2:0] ien_q;
    logic [2:0] iev;
    logic       wr_clr;
    logic       wr_en;
    assign iev    = {ovf_ev || bad_ev, evt.ret, evt.entry};
    assign wr_clr = avs_write_i && !avs_waitrequest_o &&
                    avs_address_i == `EXS_OFF_IRQ_CLR && avs_byteenable_i[0];
    assign wr_en  = avs_write_i && !avs_waitrequest_o &&
                    avs_address_i == `EXS_OFF_IRQ_EN && avs_byteenable_i[0];

    // set beats a clear landing in the same cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ist_q <= 3'h0;
        end else begin
            ist_q <= (ist_q & ~(wr_clr ? avs_writedata_i[2:0] : 3'h0)) | iev;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ien_q <= 3'h0;
        end else if (wr_en) begin
            ien_q <= avs_writedata_i[2:0];
        end
    end

    assign irq_o = |(ist_q & ien_q);

    // ============================================================
    // avalon slave: one wait cycle, answer on the second cycle
    exs_pkg::exs_bus_st_t bus_q;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_q <= exs_pkg::EXS_IDLE;
        end else begin
            case (bus_q)
                exs_pkg::EXS_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        bus_q <= exs_pkg::EXS_ACK;
                    end
                end
                exs_pkg::EXS_ACK:  bus_q <= exs_pkg::EXS_DONE;
                exs_pkg::EXS_DONE: bus_q <= exs_pkg::EXS_IDLE;
                default:           bus_q <= exs_pkg::EXS_IDLE;
            endcase
        end
    end
    assign avs_waitrequest_o = (bus_q != exs_pkg::EXS_ACK);

    // read data latched while waiting so it stands at the release edge
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (bus_q == exs_pkg::EXS_IDLE && avs_read_i) begin
            case (avs_address_i)
                `EXS_OFF_STATUS:   avs_readdata_o <= status_word;
                `EXS_OFF_IRQ_STAT: avs_readdata_o <= {29'h0, ist_q};
                `EXS_OFF_IRQ_EN:   avs_readdata_o <= {29'h0, ien_q};
                `EXS_OFF_PERIPH:   avs_readdata_o <=
                    {25'h0, (act_q >= `EXS_IRQ_BASE) ?
                            7'(act_q - `EXS_IRQ_BASE) : 7'h7F};
                default:           avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ============================================================
    // checks
    chk_thread_base: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        depth_q == 4'h0 |-> (act_q == 7'h00 && status_word[11]))
        else $error("thread mode must show zero and return-to-base");
    chk_entry_mirror: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (evt.entry && !ovf_ev) |=> service_routine_number_o ==
            $past(exc_num_i))
        else $error("active number not taken on entry");
    chk_rsv_zero: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        status_word[10:7] == 4'h0)
        else $error("reserved bits not zero");
    chk_nest_base: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        ord_cnt_q >= 4'h2 |-> !status_word[11])
        else $error("return-to-base set while nested");
    chk_fault_ignored: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (evt.entry && !ovf_ev && evt.num <= 7'h06) |=>
            $stable(ord_cnt_q))
        else $error("fault counted toward return-to-base");
    chk_act_legal: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        act_q == 7'h00 || act_q == 7'h06 || act_q == 7'h0B ||
        act_q == 7'h0E || act_q == 7'h0F || act_q inside {[2:5]} ||
        (act_q >= 7'h10 && act_q <= 7'h3F))
        else $error("illegal active exception number");
    chk_pend_range: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        status_word[18:12] < 7'h40)
        else $error("reserved pending number reported");
    chk_return_pop: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (evt.ret && depth_q == 4'h1 && !evt.entry) |=>
            act_q == 7'h00 ##1 status_word[11])
        else $error("return from last level did not reach thread");
    chk_bad_code_drop: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (exc_entry_i && !valid_code(exc_num_i) && !exc_return_i) |=>
            ($stable(act_q) && ist_q[2]))
        else $error("illegal exception number was not dropped");
    chk_single_base: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        depth_q == 4'h1 |-> status_word[11])
        else $error("single active exception must show return-to-base");
    chk_ord_nested: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (evt.entry && !ovf_ev && evt.num > 7'h06 && ord_cnt_q != 4'h0)
            |=> !status_word[11])
        else $error("nested interrupt still shows return-to-base");
    chk_fault_base: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (evt.entry && !ovf_ev && evt.num <= 7'h06 && ord_cnt_q <= 4'h1)
            |=> status_word[11])
        else $error("fault entry cleared return-to-base");
    chk_read_active: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (bus_q == exs_pkg::EXS_IDLE && avs_read_i &&
         avs_address_i == `EXS_OFF_STATUS) |=>
            avs_readdata_o[6:0] == $past(act_q))
        else $error("status read lost the active number");
    chk_read_rsv: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (bus_q == exs_pkg::EXS_IDLE && avs_read_i &&
         avs_address_i == `EXS_OFF_STATUS) |=>
            (avs_readdata_o[10:7] == 4'h0 && avs_readdata_o[31:19] == 13'h0))
        else $error("status read shows reserved bits set");
    chk_return_nonzero: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (evt.ret && !evt.entry && depth_q >= 4'h2) |=>
            service_routine_number_o != 7'h00)
        else $error("return into a preempted handler shows thread mode");
    chk_pend_follow: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        valid_code(pend_num_i) |=> status_word[18:12] == $past(pend_num_i))
        else $error("pending number not reported");
    chk_pend_reserved: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        pend_num_i >= 7'h40 |=> status_word[18:12] == 7'h00)
        else $error("reserved pending number passed through");
    chk_entry_depth: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (evt.entry && !ovf_ev) |=> depth_q == $past(depth_q) + 4'h1)
        else $error("entry did not deepen the nesting");
    chk_return_depth: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (evt.ret && !evt.entry && depth_q != 4'h0) |=>
            depth_q == $past(depth_q) - 4'h1)
        else $error("return did not pop the nesting");

    // ============================================================
    // interrupt and bus checks
    chk_set_wins: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        iev != 3'h0 |=> (ist_q & $past(iev)) == $past(iev))
        else $error("event lost against a clear");
    chk_clear_lands: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        (wr_clr && iev == 3'h0) |=>
            (ist_q & $past(avs_writedata_i[2:0])) == 3'h0)
        else $error("clear write left status bits set");
    chk_wait_single: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    chk_read_holds: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i)
        !avs_waitrequest_o |=> $stable(avs_readdata_o))
        else $error("read data moved after the answer");
endmodule
`default_nettype wire

// >>> tb/exs_core_model.sv
// core-side model: exception entry and return pulses, pending number
`timescale 1ns/100ps
`default_nettype none
module exs_core_model (
    input  wire logic       clk_i,
    output logic            entry_o,
    output logic            return_o,
    output logic      [6:0] num_o,
    output logic      [6:0] pend_o
);
    initial begin
        entry_o  = 1'b0;
        return_o = 1'b0;
        num_o    = 7'h55;
        pend_o   = 7'h00;
    end
    // ============================================================
    // op bit0 enters, bit1 returns, zero only moves the pending number
    task automatic step(input logic [1:0] op, input logic [6:0] n, p);
        entry_o  <= op[0];
        return_o <= op[1];
        num_o    <= n;
        pend_o   <= p;
        @(posedge clk_i);
        entry_o  <= 1'b0;
        return_o <= 1'b0;
        // number is only valid with a pulse, so scramble it afterwards
        num_o    <= ~n;
    endtask
endmodule
`default_nettype wire

// >>> tb/exs_status_bench.sv
// self-checking bench for the exception status block
`timescale 1ns/100ps
`default_nettype none
module exs_status_bench;
    typedef struct packed {
        logic [1:0] op;
        logic [6:0] num, pend, act;
        logic       rb;
        logic [6:0] ep;
    } exs_row_t;
    logic        clk_sys_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic [3:0]  avs_address_i   = 4'h0;
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o, q;
    logic        avs_waitrequest_o, irq_o, ent, ret;
    logic [6:0]  num, pend, srn;
    int          err_count = 0;
    int          comparisons = 0;
    exs_row_t    rows[16];
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    exs_core_model u_core (.clk_i(clk_sys_i), .entry_o(ent),
        .return_o(ret), .num_o(num), .pend_o(pend));
    exs_status u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .exc_entry_i(ent),
        .exc_return_i(ret), .exc_num_i(num), .pend_num_i(pend),
        .service_routine_number_o(srn), .irq_o(irq_o));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ============================================================
    // one avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= ~wr;
        avs_write_i     <= wr;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (avs_waitrequest_o !== 1'b0) begin
            err_count++;
            conclude();
        end else begin
            q = avs_readdata_o;
            avs_read_i  <= 1'b0;
            avs_write_i <= 1'b0;
            // idle edge: a following call never re-drives in this step
            @(posedge clk_sys_i);
        end
    endtask
    initial begin
        rows = '{'{2'h1, 7'h10, 7'h00, 7'h10, 1'h1, 7'h00},
                 '{2'h1, 7'h0B, 7'h02, 7'h0B, 1'h0, 7'h02},
                 '{2'h1, 7'h03, 7'h40, 7'h03, 1'h0, 7'h00},
                 '{2'h2, 7'h00, 7'h3F, 7'h0B, 1'h0, 7'h3F},
                 '{2'h2, 7'h00, 7'h0E, 7'h10, 1'h1, 7'h0E},
                 '{2'h1, 7'h3F, 7'h06, 7'h3F, 1'h0, 7'h06},
                 '{2'h2, 7'h00, 7'h00, 7'h10, 1'h1, 7'h00},
                 '{2'h2, 7'h00, 7'h00, 7'h00, 1'h1, 7'h00},
                 '{2'h1, 7'h02, 7'h00, 7'h02, 1'h1, 7'h00},
                 '{2'h2, 7'h00, 7'h00, 7'h00, 1'h1, 7'h00},
                 '{2'h1, 7'h06, 7'h00, 7'h06, 1'h1, 7'h00},
                 '{2'h1, 7'h0E, 7'h00, 7'h0E, 1'h1, 7'h00},
                 '{2'h1, 7'h0F, 7'h00, 7'h0F, 1'h0, 7'h00},
                 '{2'h2, 7'h00, 7'h00, 7'h0E, 1'h1, 7'h00},
                 '{2'h2, 7'h00, 7'h00, 7'h06, 1'h1, 7'h00},
                 '{2'h2, 7'h00, 7'h00, 7'h00, 1'h1, 7'h00}};
        repeat (3) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        foreach (rows[i]) begin
            u_core.step(rows[i].op, rows[i].num, rows[i].pend);
            bus(1'b0, 4'h0, 32'h0);
            check(q & 32'hFFFF_F7FF, {13'h0, rows[i].ep, 5'h0,
                  rows[i].act});
            if (rows[i].act != 7'h00) check(q[11], rows[i].rb);
            check(q[11], rows[i].rb);
            check(srn, rows[i].act);
            bus(1'b0, 4'h4, 32'h0);
            check(q[6:0], rows[i].act >= 7'h10 ? rows[i].act - 7'h10
                  : 7'h7F);
        end
        $display("table rows done");
        bus(1'b0, 4'h1, 32'h0);
        check(q, 32'h3);
        u_core.step(2'h1, 7'h08, 7'h00);
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h0000_0800);
        bus(1'b0, 4'h1, 32'h0);
        check(q, 32'h7);
        bus(1'b1, 4'h2, 32'h4);
        bus(1'b0, 4'h2, 32'h0);
        check({q[2:0], irq_o}, 4'h9);
        bus(1'b1, 4'h3, 32'h7);
        bus(1'b0, 4'h1, 32'h0);
        check(q, 32'h0);
        check(irq_o, 32'h0);
        bus(1'b0, 4'hF, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 4'h0, 32'hFFFF_FFFF);
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h0000_0800);
        $display("irq and bus tests done");
        u_core.step(2'h1, 7'h10, 7'h00);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        check({irq_o, srn}, 8'h0);
        check(avs_waitrequest_o, 32'h1);
        check(avs_readdata_o, 32'h0);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h0000_0800);
        $display("reset test done");
        conclude();
    end
endmodule
`default_nettype wire
